// ### rtl/fpec_top.sv
// flash program/erase sequencer with key lock, timing and block write cache
//
// The APB register port and the register offsets were left to the implementer.
`include "fpec_defines.svh"
`default_nettype none

// Functional notes
// - flash is programmed one byte per external-move write operation
// - a byte write can only clear bits; only erase sets them
// - 512-byte pages; erase sets every byte of the page to FF
// - writes and erases are timed internally and stall the core
// - wrong or out-of-order key blocks flash until reset
// - write or erase before full key also blocks until reset
// - each write or erase consumes the unlock
// - write enable steers writes to flash; stays until cleared
// - 8-bit-address writes above 00FF never reach flash
// - block write caches first byte, commits pair on a second byte at the next address
// - block write: a lone first byte is never committed
// - erase needs both write and erase enable; write needs write enable
module fpec_top #(
  parameter int ADDR_W   = 15,
  parameter int PAGE_W   = 9,
  parameter int WRITE_CY = (`FPEC_WRITE_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS,
  parameter int ERASE_CY = (`FPEC_ERASE_NS + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS
) (
  // clock and reset
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST,
  // apb slave
  input  wire fpec_pkg::fpec_apb_req_s APB_REQ,
  output var  fpec_pkg::fpec_apb_rsp_s APB_RSP,
  // core stall while an operation runs
  output logic                       CORE_STALL
);
  import fpec_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // ----------------------------------------------------------------------
  // storage and registers
  // ----------------------------------------------------------------------
  logic [7:0]        flash_mem [DEPTH];
  logic              write_en_reg;
  logic              erase_en_reg;
  logic              timing_en_reg;
  logic              block_en_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] raddr_reg;
  fpec_key_e         key_reg;
  fpec_state_e       state_reg;
  logic [31:0]       count_reg;
  logic [ADDR_W-1:0] op_addr_reg;
  logic [7:0]        op_data_reg;
  logic [7:0]        op_data2_reg;
  logic              op_pair_reg;
  logic              cached_reg;
  logic [ADDR_W-1:0] cache_addr_reg;
  logic [7:0]        cache_data_reg;
  logic [PAGE_W:0]   erase_idx_reg;
  logic [7:0]        rdata_reg;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       flash_wr;
  logic       busy;
  logic [7:0] wbyte;

  assign busy  = (state_reg != FPEC_IDLE);
  // a write lands only on the edge that shows ready; a held access lands again on every second edge while idle
  assign acc   = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready && !busy;
  assign wr    = acc && APB_REQ.pwrite;
  assign wbyte = APB_REQ.pwdata[7:0];
  // a data write counts as an external-move write only while write enable is set
  // flash steering
  logic mode_short;
  assign mode_short = APB_REQ.pwdata[`FPEC_WDATA_SHORT_BIT];
  assign flash_wr = wr && (APB_REQ.paddr == `FPEC_OFF_WDATA) && write_en_reg;

  logic addr_ok;
  assign addr_ok = !(mode_short && ({{(16-ADDR_W){1'b0}}, addr_reg} > `FPEC_SHORT_LIMIT));

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      write_en_reg  <= 1'b0;
      erase_en_reg  <= 1'b0;
      timing_en_reg <= 1'b0;
      block_en_reg  <= 1'b0;
      addr_reg      <= '0;
      raddr_reg     <= '0;
    end else if (wr) begin
      if (APB_REQ.paddr == `FPEC_OFF_CTRL) begin
        write_en_reg <= APB_REQ.pwdata[`FPEC_CTRL_WE_BIT];
        erase_en_reg <= APB_REQ.pwdata[`FPEC_CTRL_EE_BIT];
      end else if (APB_REQ.paddr == `FPEC_OFF_SCALE) begin
        timing_en_reg <= APB_REQ.pwdata[`FPEC_SCALE_TE_BIT];
      end else if (APB_REQ.paddr == `FPEC_OFF_CACHE) begin
        block_en_reg <= APB_REQ.pwdata[`FPEC_CACHE_BW_BIT];
      end else if (APB_REQ.paddr == `FPEC_OFF_ADDR) begin
        addr_reg <= APB_REQ.pwdata[ADDR_W-1:0];
      end else if (APB_REQ.paddr == `FPEC_OFF_RADDR) begin
        raddr_reg <= APB_REQ.pwdata[ADDR_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // key lock
  // ----------------------------------------------------------------------
  logic key_wr;
  logic op_go;
  assign key_wr = wr && (APB_REQ.paddr == `FPEC_OFF_KEY);
  // an operation starts only when unlocked, timed and addressable
  assign op_go  = flash_wr && (key_reg == FPEC_OPEN) && timing_en_reg && addr_ok;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      key_reg <= FPEC_LOCKED;
    end else if (key_reg != FPEC_BLOCKED) begin
      if (key_wr) begin
        case (key_reg)
          FPEC_LOCKED: begin
            key_reg <= (wbyte == `FPEC_KEY_FIRST) ? FPEC_KEY1 : FPEC_BLOCKED;
          end
          FPEC_KEY1: begin
            key_reg <= (wbyte == `FPEC_KEY_SECOND) ? FPEC_OPEN : FPEC_BLOCKED;
          end
          default: begin
            key_reg <= FPEC_BLOCKED;
          end
        endcase
      end else if (flash_wr) begin
        key_reg <= (key_reg == FPEC_OPEN) ? FPEC_LOCKED : FPEC_BLOCKED;
      end
    end
  end

  // ----------------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------------
  logic is_erase;
  logic second_ok;
  assign is_erase  = erase_en_reg && write_en_reg;
  // pair must land directly above the cached byte
  assign second_ok = cached_reg && (addr_reg == cache_addr_reg + 1'b1);

  // a cached first byte costs no stall; only commits and erases hold the core
  logic op_start;
  assign op_start = op_go && (is_erase || !block_en_reg || cached_reg);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_reg      <= FPEC_IDLE;
      count_reg      <= '0;
      op_addr_reg    <= '0;
      op_data_reg    <= '0;
      op_data2_reg   <= '0;
      op_pair_reg    <= 1'b0;
      cached_reg     <= 1'b0;
      cache_addr_reg <= '0;
      cache_data_reg <= '0;
      erase_idx_reg  <= '0;
    end else begin
      case (state_reg)
        FPEC_IDLE: begin
          if (op_go && is_erase) begin
            state_reg     <= FPEC_ERASE;
            op_addr_reg   <= {addr_reg[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
            count_reg     <= 32'(ERASE_CY - 1);
            erase_idx_reg <= '0;
            cached_reg    <= 1'b0;
          end else if (op_go && block_en_reg && !cached_reg) begin
            // first byte only cached, never committed alone
            cached_reg     <= 1'b1;
            cache_addr_reg <= addr_reg;
            cache_data_reg <= wbyte;
          end else if (op_go) begin
            // pair commits in one byte time
            state_reg    <= FPEC_PROG;
            count_reg    <= 32'(WRITE_CY - 1);
            op_pair_reg  <= block_en_reg && second_ok;
            op_addr_reg  <= (block_en_reg && second_ok) ? cache_addr_reg : addr_reg;
            op_data_reg  <= (block_en_reg && second_ok) ? cache_data_reg : wbyte;
            op_data2_reg <= wbyte;
            cached_reg   <= 1'b0;
          end
        end
        FPEC_PROG, FPEC_ERASE: begin
          if (count_reg == '0) begin
            state_reg <= FPEC_IDLE;
          end else begin
            count_reg <= count_reg - 32'h00000001;
          end
          if (erase_idx_reg[PAGE_W] == 1'b0 && state_reg == FPEC_ERASE) begin
            erase_idx_reg <= erase_idx_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= FPEC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // flash array (no reset: contents survive system reset)
  // ----------------------------------------------------------------------
  logic start_prog;
  assign start_prog = (state_reg == FPEC_PROG) && (count_reg == 32'(WRITE_CY - 1));

  always_ff @(posedge SYS_CLK) begin
    // only an accepted operation touches flash
    if (start_prog) begin
      flash_mem[op_addr_reg] <= flash_mem[op_addr_reg] & op_data_reg;
      if (op_pair_reg) begin
        flash_mem[op_addr_reg + 1'b1] <= flash_mem[op_addr_reg + 1'b1] & op_data2_reg;
      end
    end else if (state_reg == FPEC_ERASE && erase_idx_reg[PAGE_W] == 1'b0) begin
      flash_mem[op_addr_reg | ADDR_W'(erase_idx_reg[PAGE_W-1:0])] <= `FPEC_ERASED_BYTE;
    end
  end

  // ----------------------------------------------------------------------
  // read back and response
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    rdata_reg <= flash_mem[raddr_reg];
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (APB_REQ.paddr == `FPEC_OFF_CTRL) begin
      rd_mux[`FPEC_CTRL_WE_BIT] = write_en_reg;
      rd_mux[`FPEC_CTRL_EE_BIT] = erase_en_reg;
    end else if (APB_REQ.paddr == `FPEC_OFF_SCALE) begin
      rd_mux[`FPEC_SCALE_TE_BIT] = timing_en_reg;
    end else if (APB_REQ.paddr == `FPEC_OFF_CACHE) begin
      rd_mux[`FPEC_CACHE_BW_BIT] = block_en_reg;
    end else if (APB_REQ.paddr == `FPEC_OFF_STATUS) begin
      rd_mux[`FPEC_ST_BUSY_BIT]    = busy;
      rd_mux[`FPEC_ST_UNLOCK_BIT]  = (key_reg == FPEC_OPEN);
      rd_mux[`FPEC_ST_KEY1_BIT]    = (key_reg == FPEC_KEY1);
      rd_mux[`FPEC_ST_BLOCKED_BIT] = (key_reg == FPEC_BLOCKED);
      rd_mux[`FPEC_ST_CACHED_BIT]  = cached_reg;
    end else if (APB_REQ.paddr == `FPEC_OFF_ADDR) begin
      rd_mux[ADDR_W-1:0] = addr_reg;
    end else if (APB_REQ.paddr == `FPEC_OFF_RADDR) begin
      rd_mux[ADDR_W-1:0] = raddr_reg;
    end else if (APB_REQ.paddr == `FPEC_OFF_RDATA) begin
      rd_mux[7:0] = rdata_reg;
    end
  end

  logic known;
  assign known = (APB_REQ.paddr[1:0] == 2'b00) && (APB_REQ.paddr <= `FPEC_OFF_RDATA);

  // ready is registered: every access completes one cycle after penable, stalled while busy
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      APB_RSP    <= '0;
      CORE_STALL <= 1'b0;
    end else begin
      APB_RSP.pready  <= APB_REQ.psel && APB_REQ.penable && !busy && !APB_RSP.pready;
      APB_RSP.pslverr <= APB_REQ.psel && APB_REQ.penable && !known;
      APB_RSP.prdata  <= rd_mux;
      // stall during operation
      // stall drops on the last counted cycle so it stands exactly the operation time
      CORE_STALL      <= op_start || (busy && (count_reg != 32'h00000000));
    end
  end
endmodule // fpec_top
`default_nettype wire

// ### rtl/fpec_defines.svh
// constants for the flash program/erase controller
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define FPEC_OFF_CTRL    12'h000
`define FPEC_OFF_SCALE   12'h004
`define FPEC_OFF_KEY     12'h008
`define FPEC_OFF_CACHE   12'h00C
`define FPEC_OFF_STATUS  12'h010
`define FPEC_OFF_ADDR    12'h014
`define FPEC_OFF_WDATA   12'h018
`define FPEC_OFF_MODE    12'h01C
`define FPEC_OFF_RADDR   12'h020
`define FPEC_OFF_RDATA   12'h024

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FPEC_CTRL_WE_BIT     0
`define FPEC_CTRL_EE_BIT     1
`define FPEC_SCALE_TE_BIT    4
`define FPEC_CACHE_BW_BIT    0
`define FPEC_WDATA_SHORT_BIT 8
`define FPEC_ST_BUSY_BIT     0
`define FPEC_ST_UNLOCK_BIT   1
`define FPEC_ST_KEY1_BIT     2
`define FPEC_ST_BLOCKED_BIT  3
`define FPEC_ST_CACHED_BIT   4

// ----------------------------------------------------------------------
// keys, values, timing
// ----------------------------------------------------------------------
`define FPEC_KEY_FIRST    8'hA5
`define FPEC_KEY_SECOND   8'hF1
`define FPEC_ERASED_BYTE  8'hFF
`define FPEC_SHORT_LIMIT  16'h00FF
`define FPEC_WRITE_NS     40000
`define FPEC_ERASE_NS     20000000
`define FPEC_CLK_NS       4

`endif

// ### rtl/fpec_pkg.sv
// types for the flash program/erase controller
`default_nettype none
package fpec_pkg;
  typedef enum logic [1:0] {FPEC_IDLE, FPEC_PROG, FPEC_ERASE} fpec_state_e;
  typedef enum logic [1:0] {FPEC_LOCKED, FPEC_KEY1, FPEC_OPEN, FPEC_BLOCKED} fpec_key_e;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fpec_apb_req_s;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } fpec_apb_rsp_s;
endpackage : fpec_pkg
`default_nettype wire

// ### tb/fpec_monitor.sv
// port checker for the flash program/erase sequencer
`include "fpec_defines.svh"
`default_nettype none
module fpec_monitor #(
  parameter int WRITE_CY = 8,
  parameter int ERASE_CY = 600
) (
  // clock and reset
  input wire logic                    SYS_CLK,
  input wire logic                    RST,
  // bus and stall
  input wire fpec_pkg::fpec_apb_req_s APB_REQ,
  input wire fpec_pkg::fpec_apb_rsp_s APB_RSP,
  input wire logic                    CORE_STALL
);
  timeunit 1ns;
  timeprecision 100ps;
  import fpec_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------------------------------------
  // stall length counter
  // ----------------------------------------------------------------------
  int stall_len_reg;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) stall_len_reg <= 0;
    else if (CORE_STALL) stall_len_reg <= stall_len_reg + 1;
    else stall_len_reg <= 0;
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  pready_pulse_a: assert property (APB_RSP.pready |=> !APB_RSP.pready)
    else $error("ready held longer than one cycle");
  ready_after_access_a: assert property (APB_RSP.pready |-> $past(APB_REQ.penable))
    else $error("ready without access phase");
  // wdata writes start an operation, so their answer may wait
  answer_prompt_a: assert property ($rose(APB_REQ.penable) && APB_REQ.psel && !CORE_STALL
    && APB_REQ.paddr != `FPEC_OFF_WDATA |-> ##[1:2] APB_RSP.pready)
    else $error("idle access not answered");
  error_match_a: assert property (APB_RSP.pready |-> APB_RSP.pslverr ==
    (APB_REQ.paddr > `FPEC_OFF_RDATA || APB_REQ.paddr[1:0] != 2'b00))
    else $error("error response does not match address");
  stall_cause_a: assert property ($rose(CORE_STALL) |->
    $past(APB_REQ.paddr) == `FPEC_OFF_WDATA && $past(APB_REQ.pwrite))
    else $error("stall without data write");
  stall_hold_a: assert property ($rose(CORE_STALL) |-> CORE_STALL[*8])
    else $error("stall too short");
  stall_length_a: assert property ($fell(CORE_STALL) |->
    stall_len_reg == WRITE_CY || stall_len_reg == ERASE_CY)
    else $error("stall length wrong");
  mode_zero_a: assert property (APB_RSP.pready && !APB_REQ.pwrite &&
    APB_REQ.paddr == `FPEC_OFF_MODE |-> APB_RSP.prdata == 32'h0)
    else $error("unused register not zero");
endmodule // fpec_monitor
`default_nettype wire

// ### tb/fpec_cpu.sv
// core model: apb master issuing key, control and flash data writes
`include "fpec_defines.svh"
`default_nettype none
module fpec_cpu (
  // clock
  input wire logic                    SYS_CLK,
  // apb master side
  output var fpec_pkg::fpec_apb_req_s APB_REQ,
  input wire fpec_pkg::fpec_apb_rsp_s APB_RSP
);
  timeunit 1ns;
  timeprecision 100ps;
  import fpec_pkg::*;
  initial APB_REQ = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rdv, output logic err);
    APB_REQ <= '{1'b1, 1'b0, w, a, d};
    @(posedge SYS_CLK);
    APB_REQ.penable <= 1'b1;
    // no cycle budget here: the bench's hang guard ends a wait that never answers
    do begin
      @(posedge SYS_CLK);
    end while (APB_RSP.pready !== 1'b1);
    rdv = APB_RSP.prdata;
    err = APB_RSP.pslverr;
    // released address and data lines show junk, never the last value
    APB_REQ <= '{1'b0, 1'b0, w, ~a, ~d};
    @(posedge SYS_CLK);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    xfer(1'b0, a, 32'h0, d, e);
  endtask
  task automatic keys();
    wr(`FPEC_OFF_KEY, 32'h0000_00A5);
    wr(`FPEC_OFF_KEY, 32'h0000_00F1);
  endtask
  task automatic erase(input logic [14:0] a);
    wr(`FPEC_OFF_SCALE, 32'h10);
    wr(`FPEC_OFF_CTRL, 32'h3);
    wr(`FPEC_OFF_ADDR, {17'h0, a});
    keys();
    wr(`FPEC_OFF_WDATA, 32'h0);
    wr(`FPEC_OFF_CTRL, 32'h0);
  endtask
  task automatic prog(input logic [14:0] a, input logic [7:0] d, input logic sh, input logic last);
    wr(`FPEC_OFF_SCALE, 32'h10);
    wr(`FPEC_OFF_CTRL, 32'h1);
    wr(`FPEC_OFF_ADDR, {17'h0, a});
    keys();
    wr(`FPEC_OFF_WDATA, {23'h0, sh, d});
    if (last) wr(`FPEC_OFF_CTRL, 32'h0);
  endtask
endmodule // fpec_cpu
`default_nettype wire

// ### tb/test_flash_program_erase_control.sv
// self-checking bench for the flash program/erase sequencer
`include "fpec_defines.svh"
`default_nettype none
module test_flash_program_erase_control;
  timeunit 1ns;
  timeprecision 100ps;
  import fpec_pkg::*;
  logic          SYS_CLK = 1'b0;
  logic          RST     = 1'b1;
  fpec_apb_req_s req;
  fpec_apb_rsp_s rsp;
  logic          stall;
  int            failures = 0;
  int            checks_done = 0;
  int            cycles = 0;
  int            mem [int];
  logic [31:0]   seed = 32'hA57B;
  logic [31:0]   v;
  logic [14:0]   a;
  logic [7:0]    d;
  logic          e;
  always #2 SYS_CLK = ~SYS_CLK;
  fpec_top #(.WRITE_CY(8), .ERASE_CY(600)) i_dut (.SYS_CLK(SYS_CLK), .RST(RST),
    .APB_REQ(req), .APB_RSP(rsp), .CORE_STALL(stall));
  fpec_cpu i_cpu (.SYS_CLK(SYS_CLK), .APB_REQ(req), .APB_RSP(rsp));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic peek(input logic [14:0] pa, output logic [31:0] pd);
    i_cpu.wr(`FPEC_OFF_RADDR, {17'h0, pa});
    i_cpu.rd(`FPEC_OFF_RDATA, pd);
  endtask
  task automatic reset_dut();
    RST <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard well above the expected run length
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    reset_dut();
    i_cpu.rd(`FPEC_OFF_CTRL, v);
    check(v, 32'h0);
    i_cpu.rd(`FPEC_OFF_MODE, v);
    i_cpu.xfer(1'b0, 12'h040, 32'h0, v, e);
    check({31'h0, e}, 32'h1);
    $display("test reset done");
    i_cpu.erase(15'h0037);
    for (int i = 0; i < 512; i++) mem[i] = 32'hFF;
    for (int i = 0; i < 512; i += 73) begin
      peek(i[14:0], v);
      check(v, mem[i]);
    end
    i_cpu.rd(`FPEC_OFF_STATUS, v);
    check(v & 32'h2, 32'h0);
    $display("test erase done");
    for (int i = 0; i < 12; i++) begin
      v = xs();
      a = {11'h0, v[3:0]};
      d = v[15:8];
      i_cpu.prog(a, d, v[20], 1'b1);
      mem[a] = mem[a] & d;
      peek(a, v);
      check(v, mem[a]);
    end
    $display("test program done");
    // short address form cannot reach above the first 256 bytes
    i_cpu.prog(15'h01A0, 8'h00, 1'b1, 1'b1);
    peek(15'h01A0, v);
    check(v, mem[32'h1A0]);
    $display("test short form done");
    i_cpu.wr(`FPEC_OFF_CACHE, 32'h1);
    i_cpu.prog(15'h0120, 8'h5A, 1'b0, 1'b0);
    peek(15'h0120, v);
    check(v, mem[32'h120]);
    i_cpu.rd(`FPEC_OFF_STATUS, v);
    check(v & 32'h10, 32'h10);
    i_cpu.rd(`FPEC_OFF_CTRL, v);
    check(v, 32'h1);
    i_cpu.prog(15'h0121, 8'hC3, 1'b0, 1'b1);
    mem[32'h120] = 32'h5A;
    mem[32'h121] = 32'hC3;
    for (int i = 32'h120; i < 32'h122; i++) begin
      peek(i[14:0], v);
      check(v, mem[i]);
    end
    i_cpu.wr(`FPEC_OFF_CACHE, 32'h0);
    $display("test block write done");
    i_cpu.wr(`FPEC_OFF_KEY, 32'h0000_00F1);
    i_cpu.rd(`FPEC_OFF_STATUS, v);
    check(v & 32'h8, 32'h8);
    i_cpu.prog(15'h0140, 8'h00, 1'b0, 1'b1);
    peek(15'h0140, v);
    check(v, mem[32'h140]);
    reset_dut();
    i_cpu.wr(`FPEC_OFF_CTRL, 32'h1);
    i_cpu.wr(`FPEC_OFF_WDATA, 32'h0);
    i_cpu.rd(`FPEC_OFF_STATUS, v);
    check(v & 32'h8, 32'h8);
    peek(15'h0121, v);
    check(v, mem[32'h121]);
    $display("test lock done");
    print_verdict();
  end
endmodule // test_flash_program_erase_control
bind fpec_top fpec_monitor #(.WRITE_CY(WRITE_CY), .ERASE_CY(ERASE_CY)) i_mon (
  .SYS_CLK(SYS_CLK), .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .CORE_STALL(CORE_STALL));
`default_nettype wire
